// ### rtl/tscc_core.sv
// Two-wire register slave with conversion sequencing for local and remote
`timescale 1ns/1ps
`default_nettype none
module tscc_core
  import tscc_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR    = 7'h4c,
  parameter logic [7:0]  MAKER_ID      = 8'h3c,  // Arbitrary value
  parameter int unsigned PERIOD_CYCLES = FASTEST_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Two-wire bus pins
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  // Measurement front end
  output tscc_meas_req_type      meas_req_o,
  input  wire tscc_meas_rsp_type meas_rsp_i,
  // Results and status
  output logic [15:0]            local_temp_o,
  output logic [15:0]            remote_temp_o,
  output logic                   busy_o,
  output logic                   shutdown_o
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic               scl_meta;
    logic               scl_sync;
    logic               scl_prev;
    logic               sda_meta;
    logic               sda_sync;
    logic               sda_prev;
    tscc_bus_state_type bus_state;
    logic [3:0]         bit_cnt;
    logic [7:0]         shifter;
    logic [7:0]         tx;
    logic [7:0]         pointer;
    logic               is_read;
    logic               is_gcall;
    logic               first_byte;
    logic               master_ack;
    logic               sda_low;
    tscc_regs_type      regs;
    tscc_seq_state_type seq_state;
    logic               one_shot;
    tscc_meas_req_type  meas_req;
    logic [15:0]        local_temp;
    logic [15:0]        remote_temp;
  } tscc_core_state_type;

  localparam tscc_core_state_type STATE_RESET = '{
    scl_meta: 1'b1, scl_sync: 1'b1, scl_prev: 1'b1,
    sda_meta: 1'b1, sda_sync: 1'b1, sda_prev: 1'b1,
    bus_state: BUS_IDLE, seq_state: SEQ_IDLE,
    regs: REGS_RESET, default: '0
  };

  tscc_core_state_type s;
  tscc_core_state_type next_s;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        soft_reset;
  logic        shutdown;
  logic        rate_due;
  logic        conv_begin;
  logic [7:0]  rx_byte;
  logic [7:0]  read_data;
  logic [15:0] remote_corr;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  tscc_rate_timer #(
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_rate_timer (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .restart_i   (conv_begin | soft_reset),
    .rate_code_i (s.regs.conv_rate),
    .due_o       (rate_due)
  );

  tscc_remote_correct u_remote_correct (
    .raw_i    (meas_rsp_i.code),
    .trim_i   (s.regs.ideality_trim),
    .offset_i (s.regs.remote_offset),
    .temp_o   (remote_corr)
  );

  // -------------------------------------------------------------------------
  // Read multiplexer
  // -------------------------------------------------------------------------
  always_comb begin
    read_data = 8'h00;
    unique case (s.pointer)
      PTR_STATUS_RD: read_data[BUSY_BIT] = (s.seq_state != SEQ_IDLE);
      PTR_CONFIG_RD: read_data = s.regs.config_reg;
      PTR_RATE_RD:   read_data = s.regs.conv_rate;
      PTR_TRIM:      read_data = s.regs.ideality_trim;
      PTR_OFFSET:    read_data = s.regs.remote_offset;
      PTR_MAKER_ID:  read_data = MAKER_ID;
      default:       read_data = 8'h00;
    endcase
  end

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    next_s     = s;
    soft_reset = 1'b0;
    conv_begin = 1'b0;
    rx_byte    = s.shifter;
    shutdown   = s.regs.config_reg[SHUTDOWN_BIT];

    // Pending trigger is consumed while idle; a new trigger below still lands
    if (s.seq_state == SEQ_IDLE) begin
      next_s.one_shot = 1'b0;
    end

    // Pins pass two flip-flops before any decoding
    next_s.scl_meta = scl_i;
    next_s.scl_sync = s.scl_meta;
    next_s.scl_prev = s.scl_sync;
    next_s.sda_meta = sda_i;
    next_s.sda_sync = s.sda_meta;
    next_s.sda_prev = s.sda_sync;
    scl_rise   = s.scl_sync & ~s.scl_prev;
    scl_fall   = ~s.scl_sync & s.scl_prev;
    start_cond = s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
    stop_cond  = s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;

    next_s.meas_req.start = 1'b0;
    next_s.meas_req.abort = 1'b0;

    // Two-wire slave
    if (start_cond) begin
      next_s.bus_state = BUS_ADDR;
      next_s.bit_cnt   = 4'h0;
      next_s.sda_low   = 1'b0;
    end else if (stop_cond) begin
      next_s.bus_state = BUS_IDLE;
      next_s.sda_low   = 1'b0;
    end else begin
      unique case (s.bus_state)
        BUS_IDLE: begin
          next_s.sda_low = 1'b0;
        end
        BUS_ADDR, BUS_WRITE: begin
          if (scl_rise) begin
            next_s.shifter = {s.shifter[6:0], s.sda_sync};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == BYTE_BITS) begin
            if (s.bus_state == BUS_ADDR) begin
              if (rx_byte == GCALL_ADDR) begin
                next_s.sda_low   = 1'b1;
                next_s.is_gcall  = 1'b1;
                next_s.is_read   = 1'b0;
                next_s.bus_state = BUS_ADDR_ACK;
              end else if (rx_byte[7:1] == SLAVE_ADDR) begin
                next_s.sda_low   = 1'b1;
                next_s.is_gcall  = 1'b0;
                next_s.is_read   = rx_byte[0];
                next_s.bus_state = BUS_ADDR_ACK;
              end else begin
                next_s.bus_state = BUS_IDLE;
              end
            end else begin
              next_s.sda_low    = 1'b1;
              next_s.first_byte = 1'b0;
              next_s.bus_state  = BUS_WRITE_ACK;
              if (s.is_gcall) begin
                // Only the reset code acts; anything else is dropped
                if (s.first_byte && rx_byte == GCALL_RESET) begin
                  soft_reset = 1'b1;
                end
              end else if (s.first_byte) begin
                next_s.pointer = rx_byte;
              end else begin
                unique case (s.pointer)
                  PTR_CONFIG_WR: next_s.regs.config_reg = rx_byte & CONFIG_WR_MASK;
                  PTR_RATE_WR:   next_s.regs.conv_rate = rx_byte;
                  PTR_TRIM:      next_s.regs.ideality_trim = rx_byte;
                  PTR_OFFSET:    next_s.regs.remote_offset = rx_byte;
                  // Data byte never stored; the event counts only while shut down
                  PTR_ONE_SHOT:  next_s.one_shot = shutdown;
                  // Identification keeps its value
                  PTR_MAKER_ID:  next_s.regs = s.regs;
                  default:       next_s.regs = s.regs;
                endcase
              end
            end
          end
        end
        BUS_ADDR_ACK: begin
          if (scl_fall) begin
            next_s.bit_cnt = 4'h0;
            if (s.is_read) begin
              next_s.tx        = read_data;
              next_s.sda_low   = ~read_data[7];
              next_s.bus_state = BUS_READ;
            end else begin
              next_s.sda_low    = 1'b0;
              next_s.first_byte = 1'b1;
              next_s.bus_state  = BUS_WRITE;
            end
          end
        end
        BUS_WRITE_ACK: begin
          if (scl_fall) begin
            next_s.sda_low   = 1'b0;
            next_s.bit_cnt   = 4'h0;
            next_s.bus_state = BUS_WRITE;
          end
        end
        BUS_READ: begin
          if (scl_rise) begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (s.bit_cnt == BYTE_BITS) begin
              next_s.sda_low   = 1'b0;
              next_s.bus_state = BUS_READ_ACK;
            end else begin
              next_s.tx      = {s.tx[6:0], 1'b0};
              next_s.sda_low = ~s.tx[6];
            end
          end
        end
        BUS_READ_ACK: begin
          if (scl_rise) begin
            next_s.master_ack = ~s.sda_sync;
          end else if (scl_fall) begin
            next_s.bit_cnt = 4'h0;
            if (s.master_ack) begin
              next_s.tx        = read_data;
              next_s.sda_low   = ~read_data[7];
              next_s.bus_state = BUS_READ;
            end else begin
              next_s.bus_state = BUS_IDLE;
            end
          end
        end
      endcase
    end

    // Conversion sequencer; the front end fixes each conversion's length
    unique case (s.seq_state)
      SEQ_IDLE: begin
        if ((rate_due && !shutdown) || s.one_shot) begin
          conv_begin              = 1'b1;
          next_s.meas_req.start   = 1'b1;
          next_s.meas_req.channel = 1'b0;
          next_s.seq_state        = SEQ_LOCAL;
        end
      end
      SEQ_LOCAL: begin
        if (meas_rsp_i.done) begin
          next_s.local_temp       = meas_rsp_i.code - 16'(KELVIN_CODE);
          next_s.meas_req.start   = 1'b1;
          next_s.meas_req.channel = 1'b1;
          next_s.seq_state        = SEQ_REMOTE;
        end
      end
      SEQ_REMOTE: begin
        if (meas_rsp_i.done) begin
          next_s.remote_temp = remote_corr;
          // Idle again; shutdown then blocks further rate-timer starts, but a pending one-shot still starts
          next_s.seq_state   = SEQ_IDLE;
        end
      end
    endcase

    // Software reset wins over every register update this cycle
    if (soft_reset) begin
      next_s.regs           = REGS_RESET;
      next_s.one_shot       = 1'b0;
      next_s.seq_state      = SEQ_IDLE;
      next_s.meas_req.start = 1'b0;
      next_s.meas_req.abort = (s.seq_state != SEQ_IDLE);
      conv_begin            = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign sda_o         = 1'b0;
  assign sda_oe_o      = s.sda_low;
  assign meas_req_o    = s.meas_req;
  assign local_temp_o  = s.local_temp;
  assign remote_temp_o = s.remote_temp;
  assign busy_o        = (s.seq_state != SEQ_IDLE);
  assign shutdown_o    = s.regs.config_reg[SHUTDOWN_BIT];

endmodule
`default_nettype wire

// ### rtl/tscc_pkg.sv
// Shared constants, types and state layout for temperature conversion control
// Function
// - Rate setting read 04h, written 0Ah
// - Rate only changes idle time
// - Rate resets to 08h, sixteen per second
// - Codes 00h-09h give 2^(code-4) per second
// - Shutdown write 0Fh starts one full cycle
// - Return to shutdown after triggered cycle
// - Trigger byte is discarded
// - Signed ideality trim at 23h, resets zero
// - Remote scaled by (2088+trim)/2088
// - Offset added to remote result only
// - Acknowledge general call, evaluate next byte
// - General call 06h resets registers, aborts
// - Other general call bytes do nothing
// - Pointer FEh reads maker identification
// - Configuration bit 6 selects shutdown
package tscc_pkg;

  // -------------------------------------------------------------------------
  // Pointer addresses
  // -------------------------------------------------------------------------
  localparam logic [7:0] PTR_STATUS_RD   = 8'h02;
  localparam logic [7:0] PTR_CONFIG_RD   = 8'h03;
  localparam logic [7:0] PTR_RATE_RD     = 8'h04;
  localparam logic [7:0] PTR_CONFIG_WR   = 8'h09;
  localparam logic [7:0] PTR_RATE_WR     = 8'h0a;
  localparam logic [7:0] PTR_ONE_SHOT    = 8'h0f;
  localparam logic [7:0] PTR_OFFSET      = 8'h11;
  localparam logic [7:0] PTR_TRIM        = 8'h23;
  localparam logic [7:0] PTR_MAKER_ID    = 8'hfe;

  // -------------------------------------------------------------------------
  // Fields, codes and reset values
  // -------------------------------------------------------------------------
  localparam int         SHUTDOWN_BIT    = 6;
  localparam int         BUSY_BIT        = 7;
  localparam logic [7:0] CONFIG_WR_MASK  = 8'he4;
  localparam logic [7:0] RATE_RESET      = 8'h08;
  localparam logic [7:0] RATE_MAX_CODE   = 8'h09;
  localparam logic [7:0] GCALL_ADDR      = 8'h00;
  localparam logic [7:0] GCALL_RESET     = 8'h06;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam int         IDEALITY_BASE   = 2088;
  localparam int         KELVIN_CODE     = 4370;   // 273.15 K in 1/16 K steps
  localparam int         OFFSET_SHIFT    = 4;

  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam longint     CLOCK_HZ        = 25000000;
  localparam longint     FASTEST_PERIOD_NS = 31250000;   // 32 per second
  localparam int unsigned FASTEST_PERIOD_CYCLES =
    int'(FASTEST_PERIOD_NS * CLOCK_HZ / 1000000000);

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WRITE, BUS_WRITE_ACK, BUS_READ, BUS_READ_ACK
  } tscc_bus_state_type;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOCAL, SEQ_REMOTE} tscc_seq_state_type;

  typedef struct packed {
    logic start;
    logic channel;     // 0 local, 1 remote
    logic abort;
  } tscc_meas_req_type;

  typedef struct packed {
    logic        done;
    logic [15:0] code;  // Absolute temperature, 1/16 K
  } tscc_meas_rsp_type;

  typedef struct packed {
    logic [7:0] config_reg;
    logic [7:0] conv_rate;
    logic [7:0] ideality_trim;
    logic [7:0] remote_offset;
  } tscc_regs_type;

  localparam tscc_regs_type REGS_RESET = '{8'h00, RATE_RESET, 8'h00, 8'h00};

endpackage

// ### rtl/tscc_rate_timer.sv
// Interval timer between conversion starts
`timescale 1ns/1ps
`default_nettype none
module tscc_rate_timer
  import tscc_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = FASTEST_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       restart_i,
  input  wire logic [7:0] rate_code_i,
  // Status
  output logic            due_o
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic [31:0] limit;
  logic [3:0]  shift;

  // Period measured start to start, so the idle gap absorbs the change
  always_comb begin
    shift = (rate_code_i > RATE_MAX_CODE) ? 4'h0 : 4'(RATE_MAX_CODE - rate_code_i);
    limit = PERIOD_CYCLES << shift;
    due_o = (count >= limit - 32'h1);
    if (restart_i) begin
      next_count = 32'h0;
    end else if (!due_o) begin
      next_count = count + 32'h1;
    end else begin
      next_count = count;
    end
  end

  // Starts saturated so the first conversion follows reset at once
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count <= 32'hffffffff;
    end else begin
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// ### rtl/tscc_remote_correct.sv
// Remote channel ideality and offset correction
`timescale 1ns/1ps
`default_nettype none
module tscc_remote_correct
  import tscc_pkg::*;
(
  // Raw measurement and trims
  input  wire logic [15:0] raw_i,
  input  wire logic [7:0]  trim_i,
  input  wire logic [7:0]  offset_i,
  // Corrected result, 1/16 degree
  output logic [15:0]      temp_o
);

  logic [11:0] factor;
  logic [27:0] product;
  logic [16:0] scaled;
  logic [15:0] offset_ext;

  // Effective ideality 1.008*2088/(2088+trim) scales the result inversely
  always_comb begin
    factor     = 12'(IDEALITY_BASE + int'($signed(trim_i)));
    product    = 28'(raw_i * factor);
    scaled     = 17'(product / 28'(IDEALITY_BASE));
    offset_ext = 16'($signed(offset_i)) << OFFSET_SHIFT;
    temp_o     = 16'(scaled) - 16'(KELVIN_CODE) + offset_ext;
  end

endmodule
`default_nettype wire

// ### test/tscc_core_asserts.sv
// Port-level checks of the conversion control core
`timescale 1ns/1ps
`default_nettype none
module tscc_core_asserts
  import tscc_pkg::*;
(
  // Clock, reset and bus
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              sda_oe_o,
  // Measurement and status
  input wire tscc_meas_req_type meas_req_o,
  input wire tscc_meas_rsp_type meas_rsp_i,
  input wire logic [15:0]       local_temp_o,
  input wire logic [15:0]       remote_temp_o,
  input wire logic              busy_o,
  input wire logic              shutdown_o
);
  // ----
  // Sequencing
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic loc_done;
  logic rem_done;
  assign loc_done = meas_rsp_i.done && busy_o && !meas_req_o.channel;
  assign rem_done = meas_rsp_i.done && busy_o && meas_req_o.channel;
  AST_REMOTE_AFTER_LOCAL: assert property (
    loc_done |=> meas_req_o.start && meas_req_o.channel)
    else $error("remote start missing after local result");
  AST_IDLE_AFTER_REMOTE: assert property (rem_done |=> !busy_o)
    else $error("still busy after remote result");
  AST_LOCAL_FIRST: assert property (
    $rose(busy_o) |-> meas_req_o.start && !meas_req_o.channel)
    else $error("sequence did not open with local start");
  // Only a bus write (one-shot) may wake a shut-down sequencer
  AST_SHUTDOWN_QUIET: assert property (
    $rose(busy_o) |-> !$past(shutdown_o) || sda_oe_o || $past(sda_oe_o))
    else $error("conversion started while shut down");
  AST_SHUTDOWN_BY_BUS: assert property (
    $changed(shutdown_o) |-> sda_oe_o || $past(reset_i))
    else $error("shutdown changed without a bus write");
  AST_LOCAL_VALUE: assert property (
    loc_done |=> local_temp_o == $past(meas_rsp_i.code) - 16'(KELVIN_CODE))
    else $error("local result wrong");
  AST_REMOTE_ON_DONE: assert property (
    $changed(remote_temp_o) |-> $past(rem_done) || sda_oe_o || $past(reset_i))
    else $error("remote result changed without a conversion");
  AST_ABORT_RUNNING: assert property (
    meas_req_o.abort |-> $past(busy_o) ##1 !meas_req_o.abort)
    else $error("abort without running conversion");
  cover property (meas_req_o.abort);
  cover property (shutdown_o && $rose(busy_o));
  cover property (rem_done);
endmodule
bind tscc_core tscc_core_asserts u_asserts (
  .clk_i(clk_i), .reset_i(reset_i), .sda_oe_o(sda_oe_o), .meas_req_o(meas_req_o),
  .meas_rsp_i(meas_rsp_i), .local_temp_o(local_temp_o), .remote_temp_o(remote_temp_o),
  .busy_o(busy_o), .shutdown_o(shutdown_o));
`default_nettype wire

// ### test/tscc_host_model.sv
// Two-wire bus controller model for register access
`timescale 1ns/1ps
`default_nettype none
module tscc_host_model (
  // Clock and bus lines
  input  wire logic clk_i,
  input  wire logic sda_line_i,
  output var logic  scl_o,
  output var logic  sda_drv_o
);
  // ----
  // Bus conditions and bytes
  // ----
  localparam int QTR = 5;
  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Waits first so data never moves at a clock fall
  task automatic cond(input logic first);
    hold(QTR);
    sda_drv_o = first;
    hold(QTR);
    scl_o = 1'b1;
    hold(QTR);
    sda_drv_o = !first;
    hold(QTR);
    scl_o = !first;
  endtask
  task automatic bit_io(input logic b, output logic s);
    hold(QTR);
    sda_drv_o = b;
    hold(QTR);
    scl_o = 1'b1;
    hold(QTR);
    s = sda_line_i;
    hold(QTR);
    scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(ack_in, ack);
  endtask
  task automatic write_reg(input logic [6:0] adr, input logic [7:0] ptr,
                           input logic [7:0] data, output logic nak);
    logic [7:0] q;
    logic [2:0] a;
    cond(1'b1);
    xfer({adr, 1'b0}, 1'b1, q, a[0]);
    xfer(ptr, 1'b1, q, a[1]);
    xfer(data, 1'b1, q, a[2]);
    cond(1'b0);
    nak = |a;
  endtask
  task automatic read_reg(input logic [6:0] adr, input logic [7:0] ptr,
                          output logic [7:0] data, output logic nak);
    logic [7:0] q;
    logic [3:0] a;
    cond(1'b1);
    xfer({adr, 1'b0}, 1'b1, q, a[0]);
    xfer(ptr, 1'b1, q, a[1]);
    cond(1'b1);
    xfer({adr, 1'b1}, 1'b1, q, a[2]);
    xfer(8'hff, 1'b1, data, a[3]);
    cond(1'b0);
    nak = |a[2:0];
  endtask
  task automatic general_call(input logic [7:0] code, output logic nak);
    logic [7:0] q;
    logic a;
    cond(1'b1);
    xfer(8'h00, 1'b1, q, nak);
    xfer(code, 1'b1, q, a);
    cond(1'b0);
  endtask
endmodule
`default_nettype wire

// ### test/tscc_core_tb_top.sv
// Self-checking bench for the conversion control core
`timescale 1ns/1ps
`default_nettype none
module tscc_core_tb_top
  import tscc_pkg::*;
;
  // ----
  // Models
  // ----
  localparam int          PER   = 40;
  localparam int          LIMIT = 70000;
  localparam logic [6:0]  ADDR  = 7'h4c;
  localparam logic [7:0]  ID    = 8'h5a;  // Arbitrary identification value
  localparam logic [15:0] LOC_K = 16'h12a2;
  localparam logic [15:0] REM_K = 16'h1050;
  logic              clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              scl, sda_drv, sda_line, sda_o, sda_oe, busy, shutdown;
  tscc_meas_req_type meas_req;
  tscc_meas_rsp_type meas_rsp = '0;
  logic [15:0]       local_temp, remote_temp;
  int                conv_delay = 6;
  int                conv_cnt, cycle, start_count, loc_count, abort_count, last_start;
  int                fail_count, checked;
  always #20 clk_i = ~clk_i;
  assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
  tscc_host_model host (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl),
                        .sda_drv_o(sda_drv));
  tscc_core #(.SLAVE_ADDR(ADDR), .MAKER_ID(ID), .PERIOD_CYCLES(PER)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .meas_req_o(meas_req), .meas_rsp_i(meas_rsp),
    .local_temp_o(local_temp), .remote_temp_o(remote_temp), .busy_o(busy),
    .shutdown_o(shutdown));
  // Front end: code is garbage outside its done cycle
  always @(negedge clk_i) begin
    cycle++;
    meas_rsp.done <= 1'b0;
    meas_rsp.code <= ~meas_rsp.code;
    if (meas_req.abort) begin
      abort_count++;
      conv_cnt = 0;
    end else if (meas_req.start) begin
      start_count++;
      conv_cnt = conv_delay;
      if (!meas_req.channel) begin
        loc_count++;
        last_start = cycle;
      end
    end else if (conv_cnt == 1) begin
      meas_rsp.done <= 1'b1;
      meas_rsp.code <= meas_req.channel ? REM_K : LOC_K;
      conv_cnt = 0;
    end else if (conv_cnt > 1) begin
      conv_cnt--;
    end
    if (cycle == LIMIT) begin
      fail_count++;
      finish_test();
    end
  end
  // ----
  // Tasks and tests
  // ----
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic nak;
    host.write_reg(ADDR, p, d, nak);
    check("write ack", 16'h0000, {15'h0000, nak});
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp, input string what);
    logic [7:0] q;
    logic nak;
    host.read_reg(ADDR, p, q, nak);
    check(what, {8'h00, exp}, {7'h00, nak, q});
  endtask
  task automatic wait_local(output int t);
    int n0;
    n0 = loc_count;
    for (int i = 0; i < 3000 && loc_count == n0; i++) @(negedge clk_i);
    t = last_start;
  endtask
  task automatic finish_test();
    $display("checked %0d, fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    int t0, t1, n0;
    logic nak;
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    rd(PTR_RATE_RD, RATE_RESET, "rate reset");
    rd(PTR_TRIM, 8'h00, "trim reset");
    rd(PTR_MAKER_ID, ID, "maker id");
    wr(PTR_MAKER_ID, 8'h00);
    rd(PTR_MAKER_ID, ID, "maker id kept");
    wr(PTR_RATE_RD, 8'h03);
    rd(PTR_RATE_RD, RATE_RESET, "rate via read pointer");
    $display("test reset values done");
    for (int c = 9; c >= 3; c--) begin
      conv_delay = 3 + c;
      wr(PTR_RATE_WR, 8'(c));
      rd(PTR_RATE_RD, 8'(c), "rate readback");
      wait_local(t0);
      wait_local(t0);
      wait_local(t1);
      check("start period", 16'(PER << (9 - c)), 16'(t1 - t0));
    end
    $display("test rates done");
    wr(PTR_RATE_WR, RATE_MAX_CODE);
    wr(PTR_TRIM, 8'hf8);
    wr(PTR_OFFSET, 8'h05);
    rd(PTR_TRIM, 8'hf8, "trim readback");
    rd(PTR_OFFSET, 8'h05, "offset readback");
    wait_local(t0);
    repeat (30) @(negedge clk_i);
    check("local temp", 16'(LOC_K - KELVIN_CODE), local_temp);
    check("remote temp", 16'(int'(REM_K) * (IDEALITY_BASE - 8) / IDEALITY_BASE
          - KELVIN_CODE + 5 * 16), remote_temp);
    $display("test correction done");
    wr(PTR_CONFIG_WR, 8'h40);
    repeat (60) @(negedge clk_i);
    n0 = start_count;
    repeat (300) @(negedge clk_i);
    check("idle starts", 16'(n0), 16'(start_count));
    wr(PTR_ONE_SHOT, 8'ha5);
    repeat (300) @(negedge clk_i);
    check("one-shot starts", 16'(n0 + 2), 16'(start_count));
    check("busy", 16'h0000, {15'h0000, busy});
    rd(PTR_TRIM, 8'hf8, "trim after one-shot");
    rd(PTR_RATE_RD, RATE_MAX_CODE, "rate after one-shot");
    wr(PTR_CONFIG_WR, 8'h00);
    repeat (200) @(negedge clk_i);
    check("resumed", 16'h0001, {15'h0000, start_count > n0 + 4});
    $display("test shutdown done");
    host.general_call(8'h33, nak);
    check("general call ack", 16'h0000, {15'h0000, nak});
    rd(PTR_TRIM, 8'hf8, "trim after other code");
    wr(PTR_CONFIG_WR, 8'h40);
    repeat (60) @(negedge clk_i);
    conv_delay = 3000;
    wr(PTR_ONE_SHOT, 8'h00);
    conv_delay = 6;
    rd(PTR_STATUS_RD, 8'h80, "status busy");
    rd(PTR_CONFIG_RD, 8'h40, "config readback");
    n0 = abort_count;
    host.general_call(GCALL_RESET, nak);
    check("abort", 16'(n0 + 1), 16'(abort_count));
    check("shutdown cleared", 16'h0000, {15'h0000, shutdown});
    rd(PTR_RATE_RD, RATE_RESET, "rate after soft reset");
    rd(PTR_TRIM, 8'h00, "trim after soft reset");
    rd(PTR_OFFSET, 8'h00, "offset after soft reset");
    $display("test general call done");
    finish_test();
  end
endmodule
`default_nettype wire
